// *** shared/mpgpio_pkg.sv ***
package mpgpio_pkg;

	localparam logic [15:0] ADDR_P2_DATA = 16'hff02;
	localparam logic [15:0] ADDR_P3_DATA = 16'hff03;
	localparam logic [15:0] ADDR_P4_DATA = 16'hff04;
	localparam logic [15:0] ADDR_P2_DIR  = 16'hff22;
	localparam logic [15:0] ADDR_P3_DIR  = 16'hff23;
	localparam logic [15:0] ADDR_P4_DIR  = 16'hff24;
	localparam logic [15:0] ADDR_P2_PU   = 16'hff32;
	localparam logic [15:0] ADDR_P3_PU   = 16'hff33;
	localparam logic [15:0] ADDR_P4_PU   = 16'hff34;
	localparam logic [15:0] ADDR_ANALOG  = 16'hff84;

	localparam logic [7:0] DIR_RESET  = 8'hff;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] PU_RESET   = 8'h00;

	localparam logic [7:0] P2_MASK = 8'h0f;
	localparam logic [7:0] P3_MASK = 8'h04;
	localparam logic [7:0] P4_MASK = 8'hff;

	localparam int P2_OSC_OUT_BIT = 2;
	localparam int P2_OSC_IN_BIT  = 3;
	localparam int P2_INT_BIT     = 1;
	localparam int P3_INT_BIT     = 2;
	localparam int P3_RST_BIT     = 4;

	typedef enum logic [1:0] {
		MPG_OSC_RING     = 2'h0,
		MPG_OSC_CRYSTAL  = 2'h1,
		MPG_OSC_EXTCLK   = 2'h3
	} mpg_osc_t;

	typedef struct packed {
		mpg_osc_t osc_sel;
		logic     reset_pin_is_port;
		logic     opt_valid;
	} mpg_option_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic        bit_op;
		logic [2:0]  bit_idx;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} mpg_bus_t;

endpackage : mpgpio_pkg

// *** verilog/mpg_sync2.sv ***
`timescale 1ns/1ps
module mpg_sync2 #(
	parameter int W = 8
) (
	// Clock and reset.
	input  wire logic         clk,
	input  wire logic         arst_n,
	// Data.
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule : mpg_sync2

// *** verilog/mpg_port8.sv ***
`timescale 1ns/1ps
module mpg_port8 #(
	parameter logic [7:0] IMPL = 8'hff
) (
	// Clock and reset.
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Register writes.
	input  wire logic       data_we,
	input  wire logic       dir_we,
	input  wire logic       pu_we,
	input  wire logic [7:0] wval,
	// Synchronised pin levels.
	input  wire logic [7:0] pin_sync,
	// State.
	output logic      [7:0] latch_q,
	output logic      [7:0] dir_q,
	output logic      [7:0] pu_q,
	output logic      [7:0] rd_data,
	// Pin drive.
	output logic      [7:0] pin_o,
	output logic      [7:0] pin_oe,
	output logic      [7:0] pull_en
);
	// A write lands in the latch whatever the direction; pins only follow in output mode.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			latch_q <= mpgpio_pkg::DATA_RESET;
		end else if (data_we) begin
			latch_q <= wval & IMPL;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dir_q <= mpgpio_pkg::DIR_RESET;
		end else if (dir_we) begin
			dir_q <= wval | ~IMPL;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pu_q <= mpgpio_pkg::PU_RESET;
		end else if (pu_we) begin
			pu_q <= wval & IMPL;
		end
	end

	assign rd_data = ((dir_q & pin_sync) | (~dir_q & latch_q)) & IMPL;
	assign pin_o   = latch_q;
	assign pin_oe  = ~dir_q & IMPL;
	assign pull_en = pu_q & dir_q & IMPL;
endmodule : mpg_port8

// *** verilog/mpg_gpio.sv ***
`timescale 1ns/1ps
module mpg_gpio #(
	parameter logic [7:0] P4_IMPL = mpgpio_pkg::P4_MASK
) (
	// Clock and reset.
	input  wire logic                   clk,
	input  wire logic                   arst_n,
	// Register access.
	input  wire mpgpio_pkg::mpg_bus_t   bus,
	output logic      [7:0]             rdata,
	// Option byte.
	input  wire mpgpio_pkg::mpg_option_t option,
	// Port 2 pins.
	input  wire logic [3:0]             p2_i,
	output logic      [3:0]             p2_o,
	output logic      [3:0]             p2_oe,
	output logic      [3:0]             p2_pull_en,
	output logic      [3:0]             p2_analog_en,
	// Port 3 pins.
	input  wire logic                   p3_io_i,
	output logic                        p3_io_o,
	output logic                        p3_io_oe,
	output logic                        p3_io_pull_en,
	input  wire logic                   p3_rst_i,
	// Port 4 pins.
	input  wire logic [7:0]             p4_i,
	output logic      [7:0]             p4_o,
	output logic      [7:0]             p4_oe,
	output logic      [7:0]             p4_pull_en,
	// Clock, reset and interrupt outputs.
	output logic                        clock_input_pin_en,
	output logic                        osc_crystal_en,
	output logic                        ext_reset_req,
	output logic                        ext_int_p2,
	output logic                        ext_int_p3,
	output logic                        int_flag_set_p2,
	output logic                        int_flag_set_p3
);
	logic [7:0] p2_raw;
	logic [7:0] p3_raw;
	logic [7:0] p2_sync;
	logic [7:0] p3_sync;
	logic [7:0] p4_sync;
	logic [7:0] p2_dir;
	logic [7:0] p2_pu;
	logic [7:0] p2_rd;
	logic [7:0] p2_po;
	logic [7:0] p2_poe;
	logic [7:0] p2_pull;
	logic [7:0] p3_dir;
	logic [7:0] p3_pu;
	logic [7:0] p3_rd;
	logic [7:0] p3_po;
	logic [7:0] p3_poe;
	logic [7:0] p3_pull;
	logic [7:0] p4_dir;
	logic [7:0] p4_pu;
	logic [7:0] p4_rd;
	logic [7:0] p4_po;
	logic [7:0] p4_poe;
	logic [7:0] p4_pull;
	logic [7:0] analog_q;
	logic [7:0] wval;
	logic [7:0] cur;
	logic       we_p2d;
	logic       we_p3d;
	logic       we_p4d;
	logic       we_p2m;
	logic       we_p3m;
	logic       we_p4m;
	logic       we_p2u;
	logic       we_p3u;
	logic       we_p4u;
	logic       we_an;
	logic       p2_lvl_q;
	logic       p3_lvl_q;
	logic [7:0] p2_claim;

	// Applies a single-bit change to the byte read back from the whole port.
	function automatic logic [7:0] rmw(input logic [7:0] base, input logic [2:0] idx,
		input logic val);
		logic [7:0] r;
		r      = base;
		r[idx] = val;
		return r;
	endfunction : rmw

	assign p2_raw = {4'h0, p2_i};
	// The reset pin travels inverted, so a cleared synchroniser means pin high.
	// Otherwise every reset would be followed by a false external reset request.
	assign p3_raw = {3'h0, !p3_rst_i, 1'b0, p3_io_i, 2'h0};

	mpg_sync2 #(.W(8)) u_s2 (
		.clk    (clk),
		.arst_n (arst_n),
		.d      (p2_raw),
		.q      (p2_sync)
	);
	mpg_sync2 #(.W(8)) u_s3 (
		.clk    (clk),
		.arst_n (arst_n),
		.d      (p3_raw),
		.q      (p3_sync)
	);
	mpg_sync2 #(.W(8)) u_s4 (
		.clk    (clk),
		.arst_n (arst_n),
		.d      (p4_i),
		.q      (p4_sync)
	);

	// Readback mux; also the base of every bit operation.
	always_comb begin
		cur = 8'h00;
		if (bus.addr == mpgpio_pkg::ADDR_P2_DATA) begin
			cur = p2_rd;
		end else if (bus.addr == mpgpio_pkg::ADDR_P3_DATA) begin
			cur = p3_rd;
			cur[mpgpio_pkg::P3_RST_BIT] = !p3_sync[mpgpio_pkg::P3_RST_BIT];
		end else if (bus.addr == mpgpio_pkg::ADDR_P4_DATA) begin
			cur = p4_rd;
		end else if (bus.addr == mpgpio_pkg::ADDR_P2_DIR) begin
			cur = p2_dir;
		end else if (bus.addr == mpgpio_pkg::ADDR_P3_DIR) begin
			cur = p3_dir;
		end else if (bus.addr == mpgpio_pkg::ADDR_P4_DIR) begin
			cur = p4_dir;
		end else if (bus.addr == mpgpio_pkg::ADDR_P2_PU) begin
			cur = p2_pu;
		end else if (bus.addr == mpgpio_pkg::ADDR_P3_PU) begin
			cur = p3_pu;
		end else if (bus.addr == mpgpio_pkg::ADDR_P4_PU) begin
			cur = p4_pu;
		end else if (bus.addr == mpgpio_pkg::ADDR_ANALOG) begin
			cur = analog_q;
		end
	end

	// Input-mode bits pick up the pin level here, as the real port does.
	assign wval = bus.bit_op ? rmw(cur, bus.bit_idx, bus.wdata[0]) : bus.wdata;

	// One strobe per register; an address that matches none leaves all state alone.
	assign we_p2d = bus.wr && bus.addr == mpgpio_pkg::ADDR_P2_DATA;
	assign we_p3d = bus.wr && bus.addr == mpgpio_pkg::ADDR_P3_DATA;
	assign we_p4d = bus.wr && bus.addr == mpgpio_pkg::ADDR_P4_DATA;
	assign we_p2m = bus.wr && bus.addr == mpgpio_pkg::ADDR_P2_DIR;
	assign we_p3m = bus.wr && bus.addr == mpgpio_pkg::ADDR_P3_DIR;
	assign we_p4m = bus.wr && bus.addr == mpgpio_pkg::ADDR_P4_DIR;
	assign we_p2u = bus.wr && bus.addr == mpgpio_pkg::ADDR_P2_PU;
	assign we_p3u = bus.wr && bus.addr == mpgpio_pkg::ADDR_P3_PU;
	assign we_p4u = bus.wr && bus.addr == mpgpio_pkg::ADDR_P4_PU;
	assign we_an  = bus.wr && bus.addr == mpgpio_pkg::ADDR_ANALOG;

	// Port 2 reset state is input mode.
	// The latch is only seen through readback and pin drive, so its copy is left open.
	mpg_port8 #(.IMPL(mpgpio_pkg::P2_MASK)) u_p2 (
		.clk      (clk),
		.arst_n   (arst_n),
		.data_we  (we_p2d),
		.dir_we   (we_p2m),
		.pu_we    (we_p2u),
		.wval     (wval),
		.pin_sync (p2_sync),
		.latch_q  (),
		.dir_q    (p2_dir),
		.pu_q     (p2_pu),
		.rd_data  (p2_rd),
		.pin_o    (p2_po),
		.pin_oe   (p2_poe),
		.pull_en  (p2_pull)
	);
	// Port 3 reset state is input mode.
	mpg_port8 #(.IMPL(mpgpio_pkg::P3_MASK)) u_p3 (
		.clk      (clk),
		.arst_n   (arst_n),
		.data_we  (we_p3d),
		.dir_we   (we_p3m),
		.pu_we    (we_p3u),
		.wval     (wval),
		.pin_sync (p3_sync),
		.latch_q  (),
		.dir_q    (p3_dir),
		.pu_q     (p3_pu),
		.rd_data  (p3_rd),
		.pin_o    (p3_po),
		.pin_oe   (p3_poe),
		.pull_en  (p3_pull)
	);
	// Port 4 reset state is input mode.
	mpg_port8 #(.IMPL(P4_IMPL)) u_p4 (
		.clk      (clk),
		.arst_n   (arst_n),
		.data_we  (we_p4d),
		.dir_we   (we_p4m),
		.pu_we    (we_p4u),
		.wval     (wval),
		.pin_sync (p4_sync),
		.latch_q  (),
		.dir_q    (p4_dir),
		.pu_q     (p4_pu),
		.rd_data  (p4_rd),
		.pin_o    (p4_po),
		.pin_oe   (p4_poe),
		.pull_en  (p4_pull)
	);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			analog_q <= 8'h00;
		end else if (we_an) begin
			analog_q <= wval & mpgpio_pkg::P2_MASK;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			rdata <= cur;
		end
	end

	// Oscillator pins taken away from the port, chosen only by the option byte.
	always_comb begin
		p2_claim = 8'h00;
		case (option.osc_sel)
			mpgpio_pkg::MPG_OSC_CRYSTAL: begin
				p2_claim[mpgpio_pkg::P2_OSC_OUT_BIT] = 1'b1;
				p2_claim[mpgpio_pkg::P2_OSC_IN_BIT]  = 1'b1;
			end
			mpgpio_pkg::MPG_OSC_EXTCLK: begin
				p2_claim[mpgpio_pkg::P2_OSC_IN_BIT] = 1'b1;
			end
			default: begin
				p2_claim = 8'h00;
			end
		endcase
	end

	assign clock_input_pin_en = option.osc_sel != mpgpio_pkg::MPG_OSC_RING;
	assign osc_crystal_en     = option.osc_sel == mpgpio_pkg::MPG_OSC_CRYSTAL;

	assign p2_o         = p2_po[3:0];
	assign p2_oe        = p2_poe[3:0] & ~p2_claim[3:0] & ~analog_q[3:0];
	assign p2_pull_en   = p2_pull[3:0] & ~p2_claim[3:0];
	assign p2_analog_en = analog_q[3:0] & ~p2_claim[3:0];

	assign p3_io_o       = p3_po[mpgpio_pkg::P3_INT_BIT];
	assign p3_io_oe      = p3_poe[mpgpio_pkg::P3_INT_BIT];
	assign p3_io_pull_en = p3_pull[mpgpio_pkg::P3_INT_BIT];

	assign p4_o       = p4_po;
	assign p4_oe      = p4_poe;
	assign p4_pull_en = p4_pull;

	// Until the option byte is valid the shared pin is always reset.
	assign ext_reset_req = p3_sync[mpgpio_pkg::P3_RST_BIT]
		&& (!option.opt_valid || !option.reset_pin_is_port);

	assign ext_int_p2 = p2_sync[mpgpio_pkg::P2_INT_BIT];
	assign ext_int_p3 = p3_sync[mpgpio_pkg::P3_INT_BIT];

	// Driven level is taken from the latch output, not the pin, so an output change also edges the interrupt.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			p2_lvl_q <= 1'b0;
			p3_lvl_q <= 1'b0;
		end else begin
			p2_lvl_q <= p2_po[mpgpio_pkg::P2_INT_BIT];
			p3_lvl_q <= p3_po[mpgpio_pkg::P3_INT_BIT];
		end
	end

	assign int_flag_set_p2 = p2_poe[mpgpio_pkg::P2_INT_BIT]
		&& (p2_lvl_q != p2_po[mpgpio_pkg::P2_INT_BIT]);
	assign int_flag_set_p3 = p3_poe[mpgpio_pkg::P3_INT_BIT]
		&& (p3_lvl_q != p3_po[mpgpio_pkg::P3_INT_BIT]);
endmodule : mpg_gpio

// *** verif/mpg_pin_model.sv ***
`timescale 1ns/1ps
module mpg_pin_model #(
	parameter int W = 8
) (
	// Pad side.
	input  wire logic [W-1:0] o,
	input  wire logic [W-1:0] oe,
	input  wire logic [W-1:0] ext,
	output logic      [W-1:0] lvl
);
	// The far side always drives, so an undriven pad never floats to X.
	assign lvl = (oe & o) | (~oe & ext);
endmodule : mpg_pin_model

// *** verif/mpg_gpio_props.sv ***
`timescale 1ns/1ps
module mpg_gpio_props #(
	parameter logic [7:0] P4_IMPL = 8'hff
) (
	// Clock and reset.
	input wire logic                    clk,
	input wire logic                    arst_n,
	// Watched ports.
	input wire mpgpio_pkg::mpg_bus_t    bus,
	input wire logic [7:0]              rdata,
	input wire mpgpio_pkg::mpg_option_t option,
	input wire logic                    p3_rst_i,
	input wire logic                    p3_io_o,
	input wire logic                    p3_io_oe,
	input wire logic [3:0]              p2_oe,
	input wire logic [7:0]              p4_o,
	input wire logic [7:0]              p4_oe,
	input wire logic                    clock_input_pin_en,
	input wire logic                    ext_reset_req,
	input wire logic                    int_flag_set_p3
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_wr(a);
		bus.wr && !bus.bit_op && bus.addr == a;
	endsequence
	sequence s_pin_low;
		(!p3_rst_i && !option.reset_pin_is_port)[*3];
	endsequence
	property p_reset_in;
		$rose(arst_n) |-> p4_oe == 8'h00 && p2_oe == 4'h0 && !p3_io_oe;
	endproperty
	a_reset_in: assert property (p_reset_in) else $error("drive after reset");
	property p_dir_wr;
		s_wr(mpgpio_pkg::ADDR_P4_DIR) |=> p4_oe == (~$past(bus.wdata) & P4_IMPL);
	endproperty
	a_dir_wr: assert property (p_dir_wr) else $error("direction write");
	property p_data_wr;
		s_wr(mpgpio_pkg::ADDR_P4_DATA) |=> (p4_o & p4_oe) == ($past(bus.wdata) & p4_oe);
	endproperty
	a_data_wr: assert property (p_data_wr) else $error("data write");
	property p_dir_rd;
		bus.rd && bus.addr == mpgpio_pkg::ADDR_P4_DIR |=> rdata == (~$past(p4_oe) | ~P4_IMPL);
	endproperty
	a_dir_rd: assert property (p_dir_rd) else $error("direction read");
	property p_p3_mask;
		bus.rd && bus.addr == mpgpio_pkg::ADDR_P3_DATA |=> (rdata & 8'heb) == 8'h00;
	endproperty
	a_p3_mask: assert property (p_p3_mask) else $error("port 3 spare bits");
	property p_rst_req;
		s_pin_low |-> ext_reset_req;
	endproperty
	a_rst_req: assert property (p_rst_req) else $error("reset pin ignored");
	property p_extclk;
		(option.osc_sel == mpgpio_pkg::MPG_OSC_EXTCLK)[*2] |-> clock_input_pin_en && !p2_oe[3];
	endproperty
	a_extclk: assert property (p_extclk) else $error("clock pin claimed");
	property p_int;
		$stable(p3_io_oe) && p3_io_oe && $changed(p3_io_o) |-> ##[0:1] int_flag_set_p3;
	endproperty
	a_int: assert property (p_int) else $error("no interrupt flag");
endmodule : mpg_gpio_props

bind mpg_gpio mpg_gpio_props #(.P4_IMPL(P4_IMPL)) u_props (.clk(clk), .arst_n(arst_n),
	.bus(bus), .rdata(rdata), .option(option), .p3_rst_i(p3_rst_i), .p3_io_o(p3_io_o),
	.p3_io_oe(p3_io_oe), .p2_oe(p2_oe), .p4_o(p4_o), .p4_oe(p4_oe), .ext_reset_req(ext_reset_req),
	.clock_input_pin_en(clock_input_pin_en), .int_flag_set_p3(int_flag_set_p3));

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic                    clk, arst_n, seen;
	mpgpio_pkg::mpg_bus_t    bus;
	mpgpio_pkg::mpg_option_t option;
	logic [7:0]              rdata, p4_o, p4_oe, p4_pu, p4_x, p4_l, d4, m4, v;
	logic [3:0]              p2_o, p2_oe, p2_pu, p2_an, p2_x, p2_l;
	logic                    p3_o, p3_oe, p3_pu, p3_x, p3_l, p3_rst;
	logic                    cin_en, xtal_en, rst_req, int2, int3, fl2, fl3;
	integer                  seed;
	int                      n_fail, check_count, i;
	mpg_pin_model #(.W(4)) u_p2 (.o(p2_o), .oe(p2_oe), .ext(p2_x), .lvl(p2_l));
	mpg_pin_model #(.W(1)) u_p3 (.o(p3_o), .oe(p3_oe), .ext(p3_x), .lvl(p3_l));
	mpg_pin_model #(.W(8)) u_p4 (.o(p4_o), .oe(p4_oe), .ext(p4_x), .lvl(p4_l));
	mpg_gpio u_dut (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata(rdata), .option(option),
		.p2_i(p2_l), .p2_o(p2_o), .p2_oe(p2_oe), .p2_pull_en(p2_pu), .p2_analog_en(p2_an),
		.p3_io_i(p3_l), .p3_io_o(p3_o), .p3_io_oe(p3_oe), .p3_io_pull_en(p3_pu),
		.p3_rst_i(p3_rst), .p4_i(p4_l), .p4_o(p4_o), .p4_oe(p4_oe), .p4_pull_en(p4_pu),
		.clock_input_pin_en(cin_en), .osc_crystal_en(xtal_en), .ext_reset_req(rst_req),
		.ext_int_p2(int2), .ext_int_p3(int3), .int_flag_set_p2(fl2), .int_flag_set_p3(fl3));
	function automatic logic [7:0] exp_rd(logic [7:0] lat, logic [7:0] dir, logic [7:0] pin);
		return (dir & pin) | (~dir & lat);
	endfunction : exp_rd
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : stop_test
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic op(logic w, logic b, logic [2:0] k, logic [7:0] lo, logic [7:0] wd);
		@(negedge clk);
		bus = '{wr: w, rd: !w, bit_op: b, bit_idx: k, addr: {8'hff, lo}, wdata: wd};
		@(negedge clk);
		bus = '0;
	endtask : op
	task automatic rdchk(string nm, logic [7:0] lo, logic [7:0] e);
		op(1'b0, 1'b0, 3'h0, lo, 8'h00);
		chk(nm, e, rdata);
	endtask : rdchk
	task automatic do_reset();
		arst_n = 1'b0;
		repeat (12) @(negedge clk);
		arst_n = 1'b1;
		d4 = 8'h00;
		m4 = 8'hff;
	endtask : do_reset
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#(20000 * 100);
		n_fail++;
		stop_test();
	end
	initial begin
		seed = 32'hbe7cab8f;
		n_fail = 0;
		check_count = 0;
		bus = '0;
		option = '{mpgpio_pkg::MPG_OSC_RING, 1'b1, 1'b1};
		{p2_x, p3_x, p3_rst, p4_x} = {4'h0, 1'b0, 1'b1, 8'h00};
		do_reset();
		chk("oe", 8'h00, p4_oe | {p2_oe, 3'h0, p3_oe});
		rdchk("p2 dir", 8'h22, 8'hff);
		rdchk("p3 dir", 8'h23, 8'hff);
		rdchk("unmapped", 8'h10, 8'h00);
		op(1'b1, 1'b0, 3'h0, 8'h22, 8'h00);
		rdchk("p2 dir", 8'h22, 8'hf0);
		op(1'b1, 1'b0, 3'h0, 8'h02, 8'hff);
		rdchk("p2 data", 8'h02, 8'h0f);
		for (i = 0; i < 3; i++) begin
			option.osc_sel = mpgpio_pkg::mpg_osc_t'(i + (i >> 1));
			repeat (2) @(negedge clk);
			chk("crystal", {7'h0, i == 1}, {7'h0, xtal_en});
			chk("p2 oe", (i == 0) ? 8'h0f : ((i == 1) ? 8'h83 : 8'h87),
				{cin_en, 3'h0, p2_oe});
		end
		option.osc_sel = mpgpio_pkg::MPG_OSC_RING;
		op(1'b1, 1'b0, 3'h0, 8'h02, 8'h0d);
		chk("p2 int", 8'h03, {6'h0, int2, fl2});
		repeat (2) @(negedge clk);
		chk("p2 int", 8'h00, {6'h0, int2, fl2});
		op(1'b1, 1'b0, 3'h0, 8'h84, 8'hff);
		chk("p2 analog", 8'hf0, {p2_an, p2_oe});
		rdchk("analog", 8'h84, 8'h0f);
		op(1'b1, 1'b0, 3'h0, 8'h84, 8'h00);
		op(1'b1, 1'b0, 3'h0, 8'h32, 8'hff);
		op(1'b1, 1'b0, 3'h0, 8'h22, 8'hff);
		chk("p2 pull", 8'hfd, {p2_pu, p2_o});
		op(1'b1, 1'b0, 3'h0, 8'h23, 8'h00);
		rdchk("p3 dir", 8'h23, 8'hfb);
		op(1'b1, 1'b0, 3'h0, 8'h33, 8'hff);
		chk("p3 out", 8'h01, {6'h0, p3_pu, p3_oe});
		op(1'b1, 1'b0, 3'h0, 8'h03, 8'hff);
		seen = fl3;
		repeat (3) begin
			@(negedge clk);
			seen = seen | fl3;
		end
		chk("p3 int", 8'h03, {6'h0, int3, seen});
		rdchk("p3 data", 8'h03, 8'h14);
		op(1'b1, 1'b0, 3'h0, 8'h23, 8'hff);
		repeat (2) @(negedge clk);
		chk("p3 in", 8'h02, {5'h0, int3, p3_pu, p3_oe});
		rdchk("p3 pin", 8'h03, 8'h10);
		op(1'b1, 1'b0, 3'h0, 8'h23, 8'h00);
		rdchk("p3 latch", 8'h03, 8'h14);
		{option.opt_valid, option.reset_pin_is_port, p3_rst} = 3'b000;
		repeat (4) @(negedge clk);
		chk("rst low", 8'h01, {7'h0, rst_req});
		p3_rst = 1'b1;
		repeat (4) @(negedge clk);
		chk("rst high", 8'h00, {7'h0, rst_req});
		{option.opt_valid, option.reset_pin_is_port, p3_rst} = 3'b110;
		repeat (4) @(negedge clk);
		chk("rst port", 8'h00, {7'h0, rst_req});
		rdchk("p3 rst bit", 8'h03, 8'h04);
		p3_rst = 1'b1;
		op(1'b1, 1'b0, 3'h0, 8'h34, 8'hff);
		for (i = 0; i < 40; i++) begin
			p4_x = 8'($random(seed));
			v = 8'($random(seed));
			m4 = 8'($random(seed));
			op(1'b1, 1'b0, 3'h0, 8'h24, m4);
			repeat (2) @(negedge clk);
			op(1'b1, v[7], v[2:0], 8'h04, v[7] ? {7'h0, v[3]} : v);
			d4 = v[7] ? exp_rd(d4, m4, p4_x) : v;
			if (v[7]) d4[v[2:0]] = v[3];
			rdchk("p4 data", 8'h04, exp_rd(d4, m4, p4_x));
			chk("p4 oe", ~m4, p4_oe);
			chk("p4 pull", m4, p4_pu);
		end
		do_reset();
		rdchk("p4 dir", 8'h24, 8'hff);
		op(1'b1, 1'b0, 3'h0, 8'h24, 8'h00);
		rdchk("p4 latch", 8'h04, 8'h00);
		stop_test();
	end
endmodule : testbench
